//--- core/epa_pkg.sv
`default_nettype none

package epa_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int SAMP_W = 24;
   localparam int PWR_W  = 32;
   localparam int SUM_W  = PWR_W + 3;

   localparam logic [ADDR_W-1:0] PULSE_OUTPUT_CONFIG_ADDR = 12'h490;
   localparam logic [ADDR_W-1:0] PULSE_PHASE_SELECT_ADDR  = 12'h491;
   localparam logic [ADDR_W-1:0] ACCUMULATION_MODE_ADDR   = 12'h492;

   localparam logic [DATA_W-1:0] PULSE_OUTPUT_CONFIG_MASK  = 16'h0fff;
   localparam logic [DATA_W-1:0] PULSE_PHASE_SELECT_MASK   = 16'h0fff;
   localparam logic [DATA_W-1:0] ACCUMULATION_MODE_MASK    = 16'h01ff;
   localparam logic [DATA_W-1:0] PULSE_OUTPUT_CONFIG_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] PULSE_PHASE_SELECT_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] ACCUMULATION_MODE_RESET   = 16'h0000;

   // Per-output fields are 3 bits, output k at bits [3k+2:3k]
   localparam int FIELD_W      = 3;
   localparam int NUM_OUT      = 4;
   localparam int FREQ_BIT     = 8;
   localparam int IRECON_BIT   = 7;
   localparam int WIRING_LSB   = 4;
   localparam int REACT_LSB    = 2;
   localparam int ACTIVE_LSB   = 0;

   localparam int LINE_FREQ_50_HZ = 50;
   localparam int LINE_FREQ_60_HZ = 60;

   typedef enum logic [2:0] {
      EN_TOT_ACT   = 3'h0,
      EN_TOT_REACT = 3'h1,
      EN_TOT_APP   = 3'h2,
      EN_FND_ACT   = 3'h3,
      EN_FND_REACT = 3'h4,
      EN_FND_APP   = 3'h5
   } epa_energy_e;

   typedef enum logic [2:0] {
      WIRE_WYE4      = 3'h0,
      WIRE_DELTA3    = 3'h1,
      WIRE_WYE4_NB   = 3'h2,
      WIRE_DELTA4_NB = 3'h3,
      WIRE_LINE_LINE = 3'h4
   } epa_wiring_e;

   typedef enum logic [1:0] {
      ACC_SIGNED = 2'h0,
      ACC_ABS    = 2'h1,
      ACC_POS    = 2'h2,
      ACC_NEG    = 2'h3
   } epa_accum_e;

   typedef struct packed {
      logic signed [SAMP_W-1:0] a;
      logic signed [SAMP_W-1:0] b;
      logic signed [SAMP_W-1:0] c;
   } epa_phase_s;

   // One bit wider so that differences never wrap, except -a - c with a and c both at the most negative sample
   typedef struct packed {
      logic signed [SAMP_W:0] a;
      logic signed [SAMP_W:0] b;
      logic signed [SAMP_W:0] c;
   } epa_wide_s;

   typedef struct packed {
      logic signed [PWR_W-1:0] tot_act;
      logic signed [PWR_W-1:0] tot_react;
      logic signed [PWR_W-1:0] tot_app;
      logic signed [PWR_W-1:0] fnd_act;
      logic signed [PWR_W-1:0] fnd_react;
      logic signed [PWR_W-1:0] fnd_app;
   } epa_power_s;

endpackage : epa_pkg

`default_nettype wire

//--- core/epa_accum_gate.sv
`default_nettype none

module epa_accum_gate #(
   parameter int W = 32
) (
   input  wire logic signed [W-1:0] power,
   input  wire logic [1:0]          mode,
   input  wire logic                apply,
   output logic signed [W:0]        result
);

   logic signed [W:0] wide;

   always_comb begin
      wide = {power[W-1], power};
      result = wide;
      if (apply) begin
         unique case (mode)
            epa_pkg::ACC_SIGNED: result = wide;
            epa_pkg::ACC_ABS:    result = power[W-1] ? -wide : wide;
            epa_pkg::ACC_POS:    result = power[W-1] ? '0 : wide;
            epa_pkg::ACC_NEG:    result = power[W-1] ? wide : '0;
         endcase
      end
   end

endmodule // epa_accum_gate

`default_nettype wire

//--- core/epa_config.sv
`default_nettype none

module epa_config #(
   parameter int SAMPLE_HZ = 8000,
   parameter int PER_W     = 16
) (
   input  wire logic                            clock,
   input  wire logic                            srst,
   input  wire logic [epa_pkg::ADDR_W-1:0]      addr,
   input  wire logic [epa_pkg::DATA_W-1:0]      wdata,
   input  wire logic                            wr,
   input  wire logic                            rd,
   output logic [epa_pkg::DATA_W-1:0]           rdata,
   input  wire epa_pkg::epa_phase_s             voltage_in,
   input  wire epa_pkg::epa_phase_s             current_in,
   input  wire epa_pkg::epa_power_s             power_a,
   input  wire epa_pkg::epa_power_s             power_b,
   input  wire epa_pkg::epa_power_s             power_c,
   input  wire logic                            zx_present,
   input  wire logic [PER_W-1:0]                measured_period,
   output epa_pkg::epa_wide_s                   voltage_out,
   output epa_pkg::epa_wide_s                   current_out,
   output logic [3:0][epa_pkg::SUM_W-1:0]       pulse_energy,
   output logic                                 line_freq_60,
   output logic [PER_W-1:0]                     line_period
);

   localparam logic [PER_W-1:0] PERIOD_50 =
      PER_W'(SAMPLE_HZ / epa_pkg::LINE_FREQ_50_HZ);
   localparam logic [PER_W-1:0] PERIOD_60 =
      PER_W'(SAMPLE_HZ / epa_pkg::LINE_FREQ_60_HZ);
   localparam int PW = epa_pkg::PWR_W;
   localparam int SW = epa_pkg::SAMP_W;
   localparam int FW = epa_pkg::FIELD_W;

   // Register file
   logic [epa_pkg::DATA_W-1:0] pulse_output_config;
   logic [epa_pkg::DATA_W-1:0] pulse_phase_select;
   logic [epa_pkg::DATA_W-1:0] accumulation_mode;
   logic [epa_pkg::DATA_W-1:0] next_pulse_output_config;
   logic [epa_pkg::DATA_W-1:0] next_pulse_phase_select;
   logic [epa_pkg::DATA_W-1:0] next_accumulation_mode;
   logic [epa_pkg::DATA_W-1:0] next_rdata;

   always_comb begin
      next_pulse_output_config = pulse_output_config;
      next_pulse_phase_select  = pulse_phase_select;
      next_accumulation_mode   = accumulation_mode;
      next_rdata               = '0;
      // Masks keep reserved bits at zero whatever is written
      if (wr) begin
         unique case (addr)
            epa_pkg::PULSE_OUTPUT_CONFIG_ADDR:
               next_pulse_output_config =
                  wdata & epa_pkg::PULSE_OUTPUT_CONFIG_MASK;
            epa_pkg::PULSE_PHASE_SELECT_ADDR:
               next_pulse_phase_select =
                  wdata & epa_pkg::PULSE_PHASE_SELECT_MASK;
            epa_pkg::ACCUMULATION_MODE_ADDR:
               next_accumulation_mode =
                  wdata & epa_pkg::ACCUMULATION_MODE_MASK;
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            epa_pkg::PULSE_OUTPUT_CONFIG_ADDR:
               next_rdata = pulse_output_config;
            epa_pkg::PULSE_PHASE_SELECT_ADDR:
               next_rdata = pulse_phase_select;
            epa_pkg::ACCUMULATION_MODE_ADDR:
               next_rdata = accumulation_mode;
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pulse_output_config <= epa_pkg::PULSE_OUTPUT_CONFIG_RESET;
         pulse_phase_select  <= epa_pkg::PULSE_PHASE_SELECT_RESET;
         accumulation_mode   <= epa_pkg::ACCUMULATION_MODE_RESET;
         rdata               <= '0;
      end else begin
         pulse_output_config <= next_pulse_output_config;
         pulse_phase_select  <= next_pulse_phase_select;
         accumulation_mode   <= next_accumulation_mode;
         rdata               <= next_rdata;
      end
   end

   // Field views
   logic                    freq_sel;
   logic                    irecon;
   logic [2:0]              wiring;
   logic [1:0]              react_mode;
   logic [1:0]              active_mode;

   always_comb begin
      freq_sel    = accumulation_mode[epa_pkg::FREQ_BIT];
      irecon      = accumulation_mode[epa_pkg::IRECON_BIT];
      wiring      = accumulation_mode[epa_pkg::WIRING_LSB +: 3];
      react_mode  = accumulation_mode[epa_pkg::REACT_LSB +: 2];
      active_mode = accumulation_mode[epa_pkg::ACTIVE_LSB +: 2];
   end

   // Voltage and current reconstruction
   epa_pkg::epa_wide_s ext_v;
   epa_pkg::epa_wide_s ext_i;
   epa_pkg::epa_wide_s next_voltage_out;
   epa_pkg::epa_wide_s next_current_out;

   always_comb begin
      ext_v.a = {voltage_in.a[SW-1], voltage_in.a};
      ext_v.b = {voltage_in.b[SW-1], voltage_in.b};
      ext_v.c = {voltage_in.c[SW-1], voltage_in.c};
      ext_i.a = {current_in.a[SW-1], current_in.a};
      ext_i.b = {current_in.b[SW-1], current_in.b};
      ext_i.c = {current_in.c[SW-1], current_in.c};
      next_voltage_out = ext_v;
      // Reserved wiring codes fall back to measured voltages
      unique case (wiring)
         epa_pkg::WIRE_DELTA3:
            next_voltage_out.b = ext_v.a - ext_v.c;
         epa_pkg::WIRE_WYE4_NB:
            next_voltage_out.b = -ext_v.a - ext_v.c;
         epa_pkg::WIRE_DELTA4_NB:
            next_voltage_out.b = -ext_v.a;
         epa_pkg::WIRE_LINE_LINE: begin
            next_voltage_out.a = ext_v.a - ext_v.b;
            next_voltage_out.b = ext_v.a - ext_v.c;
            next_voltage_out.c = ext_v.c - ext_v.b;
         end
         default: ;
      endcase
      next_current_out = ext_i;
      if (irecon) begin
         next_current_out.b = -ext_i.a - ext_i.c;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         voltage_out <= '0;
         current_out <= '0;
      end else begin
         voltage_out <= next_voltage_out;
         current_out <= next_current_out;
      end
   end

   // Energy selection per pulse output and phase
   epa_pkg::epa_power_s     phase_pwr [3];
   logic signed [PW-1:0]    sel_pwr   [4][3];
   logic [1:0]              sel_mode  [4];
   logic                    sel_apply [4];
   logic signed [PW:0]      gated     [4][3];
   logic [2:0]              etype     [4];
   logic [2:0]              incl      [4];

   function automatic logic signed [PW-1:0] pick(
      input epa_pkg::epa_power_s pw,
      input logic [2:0]          t
   );
      logic signed [PW-1:0] r;
      r = pw.tot_act;
      // Codes 110 and 111 behave like total active power
      unique case (t)
         epa_pkg::EN_TOT_REACT: r = pw.tot_react;
         epa_pkg::EN_TOT_APP:   r = pw.tot_app;
         epa_pkg::EN_FND_ACT:   r = pw.fnd_act;
         epa_pkg::EN_FND_REACT: r = pw.fnd_react;
         epa_pkg::EN_FND_APP:   r = pw.fnd_app;
         default:               r = pw.tot_act;
      endcase
      return r;
   endfunction

   always_comb begin
      phase_pwr[0] = power_a;
      phase_pwr[1] = power_b;
      phase_pwr[2] = power_c;
      for (int k = 0; k < epa_pkg::NUM_OUT; k++) begin
         etype[k] = pulse_output_config[k*FW +: FW];
         incl[k]  = pulse_phase_select[k*FW +: FW];
         for (int p = 0; p < 3; p++) begin
            sel_pwr[k][p] = pick(phase_pwr[p], etype[k]);
         end
         // Apparent power is never gated by a sign mode
         unique case (etype[k])
            epa_pkg::EN_TOT_REACT, epa_pkg::EN_FND_REACT: begin
               sel_mode[k]  = react_mode;
               sel_apply[k] = 1'b1;
            end
            epa_pkg::EN_TOT_APP, epa_pkg::EN_FND_APP: begin
               sel_mode[k]  = epa_pkg::ACC_SIGNED;
               sel_apply[k] = 1'b0;
            end
            default: begin
               sel_mode[k]  = active_mode;
               sel_apply[k] = 1'b1;
            end
         endcase
      end
   end

   for (genvar k = 0; k < epa_pkg::NUM_OUT; k++) begin : g_out
      for (genvar p = 0; p < 3; p++) begin : g_ph
         epa_accum_gate #(
            .W (PW)
         ) u_gate (
            .power  (sel_pwr[k][p]),
            .mode   (sel_mode[k]),
            .apply  (sel_apply[k]),
            .result (gated[k][p])
         );
      end
   end

   logic [3:0][epa_pkg::SUM_W-1:0] next_pulse_energy;

   always_comb begin
      for (int k = 0; k < epa_pkg::NUM_OUT; k++) begin
         next_pulse_energy[k] = '0;
         for (int p = 0; p < 3; p++) begin
            if (incl[k][p]) begin
               next_pulse_energy[k] = next_pulse_energy[k]
                  + {{2{gated[k][p][PW]}}, gated[k][p]};
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pulse_energy <= '0;
      end else begin
         pulse_energy <= next_pulse_energy;
      end
   end

   // Nominal frequency and fallback line period
   logic [PER_W-1:0] next_line_period;

   always_comb begin
      next_line_period = measured_period;
      if (!zx_present) begin
         next_line_period = freq_sel ? PERIOD_60 : PERIOD_50;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         line_freq_60 <= 1'b0;
         line_period  <= PERIOD_50;
      end else begin
         line_freq_60 <= freq_sel;
         line_period  <= next_line_period;
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   logic signed [SW:0] chk_v_a;
   logic signed [SW:0] chk_v_b;
   logic signed [SW:0] chk_v_c;
   logic signed [SW:0] chk_i_a;
   logic signed [SW:0] chk_i_c;

   always_comb begin
      chk_v_a = ext_v.a;
      chk_v_b = ext_v.b;
      chk_v_c = ext_v.c;
      chk_i_a = ext_i.a;
      chk_i_c = ext_i.c;
   end

   readback_cfg_a: assert property (
      rd && addr == epa_pkg::PULSE_OUTPUT_CONFIG_ADDR && !wr
      |=> rdata == $past(pulse_output_config)
   ) else $error("pulse config readback mismatch");

   reserved_zero_a: assert property (
      wr && addr == epa_pkg::ACCUMULATION_MODE_ADDR
      ##1 rd && addr == epa_pkg::ACCUMULATION_MODE_ADDR && !wr
      |=> rdata[15:9] == '0 && rdata[8:0] == $past(wdata[8:0], 2)
   ) else $error("accumulation mode readback wrong");

   freq_follow_a: assert property (
      wr && addr == epa_pkg::ACCUMULATION_MODE_ADDR
      |=> ##1 line_freq_60 == $past(wdata[8], 2)
   ) else $error("line frequency select not applied");

   default_period_a: assert property (
      !zx_present |=> line_period == ($past(freq_sel) ? PERIOD_60 : PERIOD_50)
   ) else $error("default line period wrong");

   current_recon_a: assert property (
      irecon |=> current_out.b == -$past(chk_i_a) - $past(chk_i_c)
   ) else $error("phase B current not reconstructed");

   delta3_volt_a: assert property (
      wiring == epa_pkg::WIRE_DELTA3
      |=> voltage_out.b == $past(chk_v_a) - $past(chk_v_c)
   ) else $error("three wire delta voltage wrong");

   wye_nb_volt_a: assert property (
      wiring == epa_pkg::WIRE_WYE4_NB
      |=> voltage_out.b == -$past(chk_v_a) - $past(chk_v_c)
   ) else $error("wye non-Blondel voltage wrong");

   delta4_volt_a: assert property (
      wiring == epa_pkg::WIRE_DELTA4_NB |=> voltage_out.b == -$past(chk_v_a)
   ) else $error("four wire delta voltage wrong");

   line_line_a: assert property (
      wiring == epa_pkg::WIRE_LINE_LINE
      |=> voltage_out.a == $past(chk_v_a) - $past(chk_v_b)
       && voltage_out.c == $past(chk_v_c) - $past(chk_v_b)
   ) else $error("line to line voltages wrong");

   no_phase_a: assert property (
      incl[3] == 3'h0 |=> pulse_energy[3] == '0
   ) else $error("output four energy without phases");

   signed_active_a: assert property (
      etype[0] == 3'h0 && incl[0] == 3'h1
      && active_mode == epa_pkg::ACC_SIGNED
      |=> $signed(pulse_energy[0]) == $signed($past(power_a.tot_act))
   ) else $error("total active energy on output one wrong");

   positive_only_a: assert property (
      etype[1] == 3'h0 && active_mode == epa_pkg::ACC_POS
      |=> !pulse_energy[1][epa_pkg::SUM_W-1]
   ) else $error("positive mode produced negative energy");

   negative_only_a: assert property (
      etype[2] == 3'h1 && react_mode == epa_pkg::ACC_NEG
      |=> $signed(pulse_energy[2]) <= 0
   ) else $error("negative mode produced positive energy");

   cover_line_line_c: cover property (
      wiring == epa_pkg::WIRE_LINE_LINE ##1 irecon
   );
   cover_abs_mode_c: cover property (
      active_mode == epa_pkg::ACC_ABS && incl[0] == 3'h7
   );
   cover_freq_60_c: cover property (
      !zx_present && line_freq_60 ##1 line_period == PERIOD_60
   );

endmodule // epa_config

`default_nettype wire

//--- dv/test_energy_pulse_accum_config.sv
`default_nettype none

module test_energy_pulse_accum_config;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SHZ = 8000;
   localparam logic [11:0] CFG_A = epa_pkg::PULSE_OUTPUT_CONFIG_ADDR;
   localparam logic [11:0] SEL_A = epa_pkg::PULSE_PHASE_SELECT_ADDR;
   localparam logic [11:0] ACC_A = epa_pkg::ACCUMULATION_MODE_ADDR;

   logic                           clock;
   logic                           srst;
   logic                           wr;
   logic                           rd;
   logic [11:0]                    addr;
   logic [15:0]                    wdata;
   logic [15:0]                    rdata;
   epa_pkg::epa_phase_s            voltage_in;
   epa_pkg::epa_phase_s            current_in;
   epa_pkg::epa_power_s            power_a;
   epa_pkg::epa_power_s            power_b;
   epa_pkg::epa_power_s            power_c;
   logic                           zx_present;
   logic [15:0]                    measured_period;
   epa_pkg::epa_wide_s             voltage_out;
   epa_pkg::epa_wide_s             current_out;
   logic [3:0][epa_pkg::SUM_W-1:0] pulse_energy;
   logic                           line_freq_60;
   logic [15:0]                    line_period;

   int          err_total;
   int          samples_checked;
   int          seed;
   longint      pw[3][6];
   longint      v_a, v_b, v_c, i_a, i_b, i_c, ea, eb, ec;
   logic [15:0] cfg, sel, acc, mp;
   logic [11:0] ua;
   logic        zx;

   epa_config #(
      .SAMPLE_HZ (SHZ),
      .PER_W     (16)
   ) u_dut (
      .clock           (clock),
      .srst            (srst),
      .addr            (addr),
      .wdata           (wdata),
      .wr              (wr),
      .rd              (rd),
      .rdata           (rdata),
      .voltage_in      (voltage_in),
      .current_in      (current_in),
      .power_a         (power_a),
      .power_b         (power_b),
      .power_c         (power_c),
      .zx_present      (zx_present),
      .measured_period (measured_period),
      .voltage_out     (voltage_out),
      .current_out     (current_out),
      .pulse_energy    (pulse_energy),
      .line_freq_60    (line_freq_60),
      .line_period     (line_period)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe stays up until the next transfer, so strobes follow with no gap
   task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clock);
      rd    <= 1'b0;
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
   endtask

   task automatic reg_rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge clock);
      wr   <= 1'b0;
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      check(64'(rdata), 64'(exp));
   endtask

   task automatic stop_test;
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Gating of one phase power before it enters the sum
   function automatic longint gate(longint p, int mode, bit apply);
      if (!apply || mode == 0) return p;
      if (mode == 1) return (p < 0) ? -p : p;
      if (mode == 2) return (p > 0) ? p : 0;
      return (p < 0) ? p : 0;
   endfunction

   function automatic longint pulse_exp(int t, int inc, int am);
      int     f;
      int     m;
      bit     ap;
      longint s;
      f  = (t > 5) ? 0 : t;
      m  = (f == 1 || f == 4) ? (am >> 2) & 3 : am & 3;
      ap = !(f == 2 || f == 5);
      s  = 0;
      for (int ph = 0; ph < 3; ph++) begin
         if (inc[ph]) s += gate(pw[ph][f], m, ap);
      end
      return s;
   endfunction

   function automatic epa_pkg::epa_power_s mk(int ph);
      epa_pkg::epa_power_s p;
      p.tot_act   = pw[ph][0][31:0];
      p.tot_react = pw[ph][1][31:0];
      p.tot_app   = pw[ph][2][31:0];
      p.fnd_act   = pw[ph][3][31:0];
      p.fnd_react = pw[ph][4][31:0];
      p.fnd_app   = pw[ph][5][31:0];
      return p;
   endfunction

   initial begin
      seed = 19899;
      err_total = 0;
      samples_checked = 0;
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      voltage_in = '0;
      current_in = '0;
      power_a = '0;
      power_b = '0;
      power_c = '0;
      zx_present = 1'b0;
      measured_period = '0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1;
      check(64'(line_period), 64'(SHZ / 50));
      check(64'(line_freq_60), 64'h0);
      check(64'(pulse_energy), 64'h0);
      reg_rd(CFG_A, 16'h0000);
      reg_rd(SEL_A, 16'h0000);
      reg_rd(ACC_A, 16'h0000);
      @(posedge clock);
      #1;
      check(64'(rdata), 64'h0);
      for (int i = 0; i < 32; i++) begin
         // Each output walks through all eight type codes over the loop
         cfg = 16'($random(seed));
         for (int k = 0; k < 4; k++) cfg[3*k +: 3] = 3'((i + 3 * k) % 8);
         sel = 16'($random(seed));
         if (i == 0) sel[2:0] = 3'h1;
         acc = 16'($random(seed));
         // Modes follow i[4:3] so every type code meets every mode
         acc[8:0] = {i[4], i[3], i[2:0], i[4:3], i[3], i[4]};
         ua = 12'h800 | 12'($random(seed));
         reg_wr(CFG_A, cfg);
         reg_wr(SEL_A, sel);
         reg_wr(ACC_A, acc);
         reg_rd(ACC_A, acc & epa_pkg::ACCUMULATION_MODE_MASK);
         reg_wr(ua, 16'($random(seed)));
         v_a = longint'($signed(24'($random(seed))));
         v_b = longint'($signed(24'($random(seed))));
         v_c = longint'($signed(24'($random(seed))));
         i_a = longint'($signed(24'($random(seed))));
         i_b = longint'($signed(24'($random(seed))));
         i_c = longint'($signed(24'($random(seed))));
         for (int ph = 0; ph < 3; ph++) begin
            for (int f = 0; f < 6; f++) pw[ph][f] = longint'($random(seed));
         end
         zx = 1'($random(seed));
         mp = 16'($random(seed));
         voltage_in <= {24'(v_a), 24'(v_b), 24'(v_c)};
         current_in <= {24'(i_a), 24'(i_b), 24'(i_c)};
         power_a <= mk(0);
         power_b <= mk(1);
         power_c <= mk(2);
         zx_present <= zx;
         measured_period <= mp;
         reg_rd(CFG_A, cfg & epa_pkg::PULSE_OUTPUT_CONFIG_MASK);
         reg_rd(SEL_A, sel & epa_pkg::PULSE_PHASE_SELECT_MASK);
         reg_rd(ACC_A, acc & epa_pkg::ACCUMULATION_MODE_MASK);
         reg_rd(ua, 16'h0000);
         repeat (2) @(posedge clock);
         #1;
         ea = v_a;
         eb = v_b;
         ec = v_c;
         case (acc[6:4])
            3'h1: eb = v_a - v_c;
            3'h2: eb = -v_a - v_c;
            3'h3: eb = -v_a;
            3'h4: begin
               ea = v_a - v_b;
               eb = v_a - v_c;
               ec = v_c - v_b;
            end
            default: ;
         endcase
         check(64'(voltage_out.a), ea);
         check(64'(voltage_out.b), eb);
         check(64'(voltage_out.c), ec);
         check(64'(current_out.a), i_a);
         check(64'(current_out.b), acc[7] ? -i_a - i_c : i_b);
         check(64'(current_out.c), i_c);
         check(64'(line_freq_60), 64'(acc[8]));
         check(64'(line_period),
               zx ? 64'(mp) : 64'(acc[8] ? SHZ / 60 : SHZ / 50));
         for (int k = 0; k < 4; k++) begin
            check(64'($signed(pulse_energy[k])),
                  pulse_exp(int'(cfg[3*k +: 3]), int'(sel[3*k +: 3]),
                            int'(acc[3:0])));
         end
      end
      stop_test();
   end

endmodule // test_energy_pulse_accum_config

`default_nettype wire
